// [tpw_params.svh]
`ifndef TPW_PARAMS_SVH
`define TPW_PARAMS_SVH
// Register byte offsets on the bus
`define TPW_OFS_PERIOD   8'h00
`define TPW_OFS_DEAD     8'h04
`define TPW_OFS_PDEL     8'h08
`define TPW_OFS_SYNCW    8'h0C
`define TPW_OFS_DUTY_A   8'h10
`define TPW_OFS_DUTY_B   8'h14
`define TPW_OFS_DUTY_C   8'h18
`define TPW_OFS_SEG      8'h1C
`define TPW_OFS_GATE     8'h20
`define TPW_OFS_MODE     8'h24
`define TPW_OFS_SWTRIP   8'h28
`define TPW_OFS_STAT     8'h2C
`define TPW_OFS_EVT      8'h30
// Field positions
`define TPW_MODE_DOUBLE  6
`define TPW_MODE_RESTART 0
`define TPW_SEG_XOVER    6
`define TPW_GATE_HI_EN   8
`define TPW_GATE_LO_EN   9
`define TPW_STAT_TRIPPIN 0
`define TPW_STAT_TRIPPED 1
`define TPW_STAT_HALF    3
`define TPW_EVT_SYNC     0
`define TPW_EVT_TRIP     1
// Reset values
`define TPW_RST_PERIOD   16'h03E8
`define TPW_RST_DEAD     10'h000
`define TPW_RST_PDEL     16'h0000
`define TPW_RST_SYNCW    8'h27
`define TPW_RST_DUTY     16'h0000
`define TPW_RST_SEG      9'h03F
`define TPW_RST_GATE     10'h000
`define TPW_RST_MODE     8'h00
`endif

// [tpw_pkg.sv]
package tpw_pkg;
  typedef struct packed {
    logic [15:0] period;
    logic [9:0]  dead;
    logic [15:0] pdel;
    logic [7:0]  syncw;
    logic [15:0] duty_a;
    logic [15:0] duty_b;
    logic [15:0] duty_c;
    logic [8:0]  seg;
  } tpw_cfg_t;

  typedef enum logic {
    TPW_FIRST  = 1'b0,
    TPW_SECOND = 1'b1
  } tpw_half_t;
endpackage

// [tpw_three_phase_pwm.sv]
`timescale 1ns/10ps
`include "tpw_params.svh"
module tpw_three_phase_pwm
  import tpw_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        trip_in_n,
  input  wire logic [2:0]  sense_over_hi,
  input  wire logic [2:0]  sense_under_lo,
  input  wire logic [2:0]  sense_floating,
  output logic             phase_a_high_out,
  output logic             phase_a_low_out,
  output logic             phase_b_high_out,
  output logic             phase_b_low_out,
  output logic             phase_c_high_out,
  output logic             phase_c_low_out,
  output logic             period_sync_pulse,
  output logic             sync_irq,
  output logic             trip_irq
);

  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] sel);
    wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // Pulse deletion: too-short on or off times collapse to 0 or full
  function automatic logic [15:0] clamp_duty(input logic [15:0] duty, input logic [15:0] tm,
                                             input logic [15:0] pd);
    if (duty < pd)
      clamp_duty = 16'h0000;
    else if (duty > tm || (tm - duty) < pd)
      clamp_duty = tm;
    else
      clamp_duty = duty;
  endfunction

  // Cycles since the raw level last moved, saturating
  function automatic logic [10:0] dt_age(input logic moved, input logic [10:0] age);
    if (moved)
      dt_age = 11'h000;
    else if (age == 11'h7FF)
      dt_age = age;
    else
      dt_age = age + 11'h001;
  endfunction

  logic [1:0]  rst_sync;
  logic        rst_q_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_q_n = rst_sync[1];

  // Software-side registers
  tpw_cfg_t    cfg;
  tpw_cfg_t    act;
  logic [9:0]  gate_chop_config;
  logic [7:0]  mode_control_reg;
  logic [1:0]  evt;
  logic        tripped;
  logic [2:0]  trip_pipe;
  logic        trip_pin_lvl;
  logic [15:0] cnt;
  tpw_half_t   half;
  logic        sync_start;
  logic [8:0]  sync_left;
  logic        wr_en;
  logic        rd_en;
  logic        sw_trip_wr;
  logic        restart_wr;
  logic        hw_fault_now;
  logic        async_off;
  logic [2:0][8:0] sense_pipe;
  logic [8:0]  sense_lvl;
  logic        fault_sync;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign sw_trip_wr = wr_en && wb_adr_i == `TPW_OFS_SWTRIP;
  assign restart_wr = wr_en && wb_adr_i == `TPW_OFS_MODE && wb_sel_i[0]
                      && wb_dat_i[`TPW_MODE_RESTART];

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      cfg.period       <= `TPW_RST_PERIOD;
      cfg.dead         <= `TPW_RST_DEAD;
      cfg.pdel         <= `TPW_RST_PDEL;
      cfg.syncw        <= `TPW_RST_SYNCW;
      cfg.duty_a       <= `TPW_RST_DUTY;
      cfg.duty_b       <= `TPW_RST_DUTY;
      cfg.duty_c       <= `TPW_RST_DUTY;
      cfg.seg          <= `TPW_RST_SEG;
      gate_chop_config <= `TPW_RST_GATE;
      mode_control_reg <= `TPW_RST_MODE;
    end else if (wr_en) begin
      case (wb_adr_i)
        `TPW_OFS_PERIOD: cfg.period <= wr16(cfg.period, wb_dat_i, wb_sel_i);
        `TPW_OFS_DEAD:   cfg.dead   <= 10'(wr16({6'h00, cfg.dead}, wb_dat_i, wb_sel_i));
        `TPW_OFS_PDEL:   cfg.pdel   <= wr16(cfg.pdel, wb_dat_i, wb_sel_i);
        `TPW_OFS_SYNCW: begin
          if (wb_sel_i[0])
            cfg.syncw <= wb_dat_i[7:0];
        end
        `TPW_OFS_DUTY_A: cfg.duty_a <= wr16(cfg.duty_a, wb_dat_i, wb_sel_i);
        `TPW_OFS_DUTY_B: cfg.duty_b <= wr16(cfg.duty_b, wb_dat_i, wb_sel_i);
        `TPW_OFS_DUTY_C: cfg.duty_c <= wr16(cfg.duty_c, wb_dat_i, wb_sel_i);
        `TPW_OFS_SEG:    cfg.seg    <= 9'(wr16({7'h00, cfg.seg}, wb_dat_i, wb_sel_i));
        `TPW_OFS_GATE:   gate_chop_config <= 10'(wr16({6'h00, gate_chop_config}, wb_dat_i, wb_sel_i));
        `TPW_OFS_MODE: begin
          // Restart bit is a command, never stored
          if (wb_sel_i[0])
            mode_control_reg <= {wb_dat_i[7:1], 1'b0};
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n)
      wb_dat_o <= 32'h0000_0000;
    else if (rd_en) begin
      case (wb_adr_i)
        `TPW_OFS_PERIOD: wb_dat_o <= {16'h0000, cfg.period};
        `TPW_OFS_DEAD:   wb_dat_o <= {22'h000000, cfg.dead};
        `TPW_OFS_PDEL:   wb_dat_o <= {16'h0000, cfg.pdel};
        `TPW_OFS_SYNCW:  wb_dat_o <= {24'h000000, cfg.syncw};
        `TPW_OFS_DUTY_A: wb_dat_o <= {16'h0000, cfg.duty_a};
        `TPW_OFS_DUTY_B: wb_dat_o <= {16'h0000, cfg.duty_b};
        `TPW_OFS_DUTY_C: wb_dat_o <= {16'h0000, cfg.duty_c};
        `TPW_OFS_SEG:    wb_dat_o <= {23'h000000, cfg.seg};
        `TPW_OFS_GATE:   wb_dat_o <= {22'h000000, gate_chop_config};
        `TPW_OFS_MODE:   wb_dat_o <= {24'h000000, mode_control_reg};
        `TPW_OFS_STAT:   wb_dat_o <= {28'h0000000, half == TPW_SECOND, 1'b0,
                                      tripped, trip_pin_lvl};
        `TPW_OFS_EVT:    wb_dat_o <= {30'h00000000, evt};
        default:         wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Trip pin for status and latching; async path below bypasses this
  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n)
      trip_pipe <= 3'h7;
    else
      trip_pipe <= {trip_pipe[1:0], trip_in_n};
  end

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n)
      trip_pin_lvl <= 1'b1;
    else if (trip_pipe[2] == trip_pipe[1])
      trip_pin_lvl <= trip_pipe[2];
  end

  // Sense comparators filtered like the trip pin; a bit moves once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      sense_pipe <= {3{9'h000}};
      sense_lvl  <= 9'h000;
    end else begin
      sense_pipe <= {sense_pipe[1:0], sense_floating, sense_under_lo, sense_over_hi};
      sense_lvl  <= (sense_pipe[2] & sense_pipe[1]) | (sense_lvl & (sense_pipe[2] | sense_pipe[1]));
    end
  end

  assign hw_fault_now = !trip_in_n || |sense_over_hi || |sense_under_lo || |sense_floating;
  assign async_off = hw_fault_now || tripped;
  // Filtered pin causes plus the software trip write, so the tripped latch never samples a raw pin
  assign fault_sync = !trip_pin_lvl || |sense_lvl || sw_trip_wr;

  // held until restart with cause gone
  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n)
      tripped <= 1'b0;
    else if (fault_sync)
      tripped <= 1'b1;
    else if (restart_wr)
      tripped <= 1'b0;
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n)
      evt <= 2'h0;
    else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `TPW_EVT_SYNC && sync_start) || (i == `TPW_EVT_TRIP && fault_sync && !tripped))
          evt[i] <= 1'b1;
        else if (wr_en && wb_adr_i == `TPW_OFS_EVT && wb_sel_i[0] && wb_dat_i[i])
          evt[i] <= 1'b0;
      end
    end
  end
  assign sync_irq = evt[`TPW_EVT_SYNC];
  assign trip_irq = evt[`TPW_EVT_TRIP];

  // up in first half, down in second
  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      cnt  <= 16'h0000;
      half <= TPW_FIRST;
    end else if (tripped) begin
      cnt  <= 16'h0000;
      half <= TPW_FIRST;
    end else if (half == TPW_FIRST) begin
      if (cnt + 16'h0001 >= act.period) begin
        half <= TPW_SECOND;
      end else
        cnt <= cnt + 16'h0001;
    end else begin
      if (cnt == 16'h0000)
        half <= TPW_FIRST;
      else
        cnt <= cnt - 16'h0001;
    end
  end

  // sync at start, plus midpoint in double
  always_comb begin
    sync_start = 1'b0;
    if (!tripped) begin
      if (half == TPW_SECOND && cnt == 16'h0000)
        sync_start = 1'b1;
      else if (half == TPW_FIRST && cnt + 16'h0001 >= act.period
               && mode_control_reg[`TPW_MODE_DOUBLE])
        sync_start = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n)
      sync_left <= 9'h000;
    else if (sync_start)
      sync_left <= {1'b0, cfg.syncw} + 9'h001;
    else if (sync_left != 9'h000)
      sync_left <= sync_left - 9'h001;
  end
  assign period_sync_pulse = sync_left != 9'h000;

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n)
      act <= {`TPW_RST_PERIOD, `TPW_RST_DEAD, `TPW_RST_PDEL, `TPW_RST_SYNCW,
              `TPW_RST_DUTY, `TPW_RST_DUTY, `TPW_RST_DUTY, `TPW_RST_SEG};
    else if (sync_start || tripped)
      act <= cfg;
  end

  logic [15:0] duty_eff [3];
  logic [2:0]  raw;
  logic [2:0]  raw_q;
  logic [10:0] dt_cnt [3];
  logic [2:0]  hi_t;
  logic [2:0]  lo_t;
  logic [10:0] dt_ticks;

  assign duty_eff[0] = clamp_duty(act.duty_a, act.period, act.pdel);
  assign duty_eff[1] = clamp_duty(act.duty_b, act.period, act.pdel);
  assign duty_eff[2] = clamp_duty(act.duty_c, act.period, act.pdel);
  assign dt_ticks = {act.dead, 1'b0};

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (tripped)
        raw[p] = 1'b0;
      else
        raw[p] = {1'b0, cnt} + {1'b0, duty_eff[p]} >= {1'b0, act.period};
    end
  end

  // Turn-on waits dt_ticks after the raw edge, turn-off is at once; zero means no gap
  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      for (int p = 0; p < 3; p++)
        dt_cnt[p] <= 11'h000;
      raw_q <= 3'h0;
      hi_t  <= 3'h0;
      lo_t  <= 3'h0;
    end else begin
      raw_q <= raw;
      for (int p = 0; p < 3; p++) begin
        dt_cnt[p] <= dt_age(raw[p] != raw_q[p], dt_cnt[p]);
        hi_t[p]   <= raw[p] && dt_age(raw[p] != raw_q[p], dt_cnt[p]) >= dt_ticks;
        lo_t[p]   <= !raw[p] && !tripped && dt_age(raw[p] != raw_q[p], dt_cnt[p]) >= dt_ticks;
      end
    end
  end

  logic [7:0] chop_div;
  logic       chop;

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      chop_div <= 8'h00;
      chop     <= 1'b0;
    end else if (chop_div >= gate_chop_config[7:0]) begin
      chop_div <= 8'h00;
      chop     <= !chop;
    end else
      chop_div <= chop_div + 8'h01;
  end

  logic [5:0] drive;

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n)
      drive <= 6'h00;
    else begin
      for (int p = 0; p < 3; p++) begin
        drive[2*p]   <= act.seg[2*p] && (act.seg[`TPW_SEG_XOVER+p] ? lo_t[p] : hi_t[p])
                        && (chop || !gate_chop_config[`TPW_GATE_HI_EN]);
        drive[2*p+1] <= act.seg[2*p+1] && (act.seg[`TPW_SEG_XOVER+p] ? hi_t[p] : lo_t[p])
                        && (chop || !gate_chop_config[`TPW_GATE_LO_EN]);
      end
    end
  end

  assign phase_a_high_out = drive[0] && !async_off;
  assign phase_a_low_out  = drive[1] && !async_off;
  assign phase_b_high_out = drive[2] && !async_off;
  assign phase_b_low_out  = drive[3] && !async_off;
  assign phase_c_high_out = drive[4] && !async_off;
  assign phase_c_low_out  = drive[5] && !async_off;

endmodule

// [tpw_pwm_monitor.sv]
`timescale 1ns/10ps
module tpw_pwm_monitor
  import tpw_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        trip_in_n,
  input wire logic [2:0]  sense_over_hi,
  input wire logic [2:0]  sense_under_lo,
  input wire logic [2:0]  sense_floating,
  input wire logic        phase_a_high_out,
  input wire logic        phase_a_low_out,
  input wire logic        phase_b_high_out,
  input wire logic        phase_b_low_out,
  input wire logic        phase_c_high_out,
  input wire logic        phase_c_low_out,
  input wire logic        period_sync_pulse,
  input wire logic        sync_irq,
  input wire logic        trip_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] outs;
  logic       wr_go;
  logic       prev_s;
  logic [7:0] w_cfg;
  logic [7:0] w_lat;
  logic [8:0] hi_n;
  assign outs = {phase_c_low_out, phase_c_high_out, phase_b_low_out, phase_b_high_out,
                 phase_a_low_out, phase_a_high_out};
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // Width register mirrored from bus writes, latched at sync rise
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_cfg <= 8'h27;
    end else if (wr_go && wb_adr_i == 8'h0C) begin
      w_cfg <= wb_dat_i[7:0];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_s <= 1'b0;
      hi_n   <= 9'h000;
      w_lat  <= 8'h00;
    end else begin
      prev_s <= period_sync_pulse;
      hi_n   <= period_sync_pulse ? hi_n + 9'h001 : 9'h000;
      if (period_sync_pulse && !prev_s) begin
        w_lat <= w_cfg;
      end
    end
  end
  property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_trip_off; !trip_in_n |-> outs == 6'h00; endproperty
  a_trip_off: assert property (p_trip_off) else $error("outputs on with trip pin low");
  property p_sense_off; |{sense_over_hi, sense_under_lo, sense_floating} |-> outs == 6'h00; endproperty
  a_sense_off: assert property (p_sense_off) else $error("outputs on with sense fault");
  property p_no_shoot; !(outs[0] && outs[1]) && !(outs[2] && outs[3]) && !(outs[4] && outs[5]); endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both switches of a pair on");
  property p_sync_irq; $rose(period_sync_pulse) |-> ##[0:2] sync_irq; endproperty
  a_sync_irq: assert property (p_sync_irq) else $error("no sync event");
  property p_trip_irq; $fell(trip_in_n) |-> ##[0:6] trip_irq; endproperty
  a_trip_irq: assert property (p_trip_irq) else $error("no shutdown event");
  property p_irq_hold; trip_irq && !(wr_go && wb_adr_i == 8'h30 && wb_dat_i[1]) |=> trip_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("shutdown event lost");
  property p_sync_w; $fell(period_sync_pulse) && !trip_irq |-> hi_n == {1'b0, w_lat} + 9'h001; endproperty
  a_sync_w: assert property (p_sync_w) else $error("sync width wrong");
  c_sync: cover property ($rose(period_sync_pulse));
  c_trip: cover property ($fell(trip_in_n));
  c_sense: cover property ($rose(|sense_floating));
endmodule
bind tpw_three_phase_pwm tpw_pwm_monitor i_tpw_pwm_monitor (.*);

// [tpw_gate_drv_model.sv]
`timescale 1ns/10ps
// Gate driver stand-in: counts on-cycles of each switch between clears
module tpw_gate_drv_model (
  input  wire logic       core_clk,
  input  wire logic       clr,
  input  wire logic [5:0] gate,
  output logic [5:0][7:0] on_cnt
);
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 6; i++) begin
      on_cnt[i] <= clr ? 8'h00 : on_cnt[i] + {7'h00, gate[i]};
    end
  end
endmodule

// [tpw_three_phase_pwm_tb.sv]
`timescale 1ns/10ps
`include "tpw_params.svh"
module tpw_three_phase_pwm_tb;
  import tpw_pkg::*;
  logic core_clk, rst_n, cyc, stb, we, trip_n, clr, ack, sp, s_irq, t_irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, rd_q;
  logic [8:0] sns;
  logic [5:0] g;
  logic [5:0][7:0] on_cnt;
  int num_errors, samples_checked, ncyc, nhi;
  tpw_three_phase_pwm i_tpw_three_phase_pwm (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .trip_in_n(trip_n), .sense_over_hi(sns[2:0]), .sense_under_lo(sns[5:3]),
    .sense_floating(sns[8:6]), .phase_a_high_out(g[0]), .phase_a_low_out(g[1]),
    .phase_b_high_out(g[2]), .phase_b_low_out(g[3]), .phase_c_high_out(g[4]),
    .phase_c_low_out(g[5]), .period_sync_pulse(sp), .sync_irq(s_irq), .trip_irq(t_irq));
  tpw_gate_drv_model i_tpw_gate_drv_model (.core_clk(core_clk), .clr(clr), .gate(g), .on_cnt(on_cnt));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] v);
    samples_checked++;
    if (v !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask
  // Classic cycle: hold everything until ack is seen at a rising edge
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
    int n;
    @(posedge core_clk);
    {cyc, stb, we, adr, sel, dw} <= {2'b11, w, a, 4'h3, 16'h0000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (ack === 1'b1)
        break;
    end
    if (n == 20) begin
      num_errors++;
      end_sim();
    end
    // Read data is taken at the same edge that shows ack high
    rd_q = dr;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic rc(logic [7:0] a, logic [15:0] e, logic [15:0] m);
    bus(1'b0, a, 16'h0000);
    chk("read", e, rd_q[15:0] & m);
  endtask
  // Waits for a sync rise; nhi is the prior pulse width, ncyc the rise spacing
  task automatic sy();
    ncyc = 0;
    do begin @(negedge core_clk); ncyc++; end while (sp === 1'b1 && ncyc < 4200);
    nhi = ncyc;
    do begin @(negedge core_clk); ncyc++; end while (sp !== 1'b1 && ncyc < 4200);
    if (ncyc >= 4200) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic ck6(logic [47:0] e);
    sy();
    sy();
    cnt6(e);
  endtask
  // Counts one full period of gate on-time; no sync needed, so usable while tripped
  task automatic cnt6(logic [47:0] e);
    @(posedge core_clk) clr <= 1'b1;
    @(posedge core_clk) clr <= 1'b0;
    repeat (40) @(posedge core_clk);
    @(negedge core_clk);
    for (int i = 0; i < 6; i++) chk("gate on-time", {8'h00, e[8*i+:8]}, {8'h00, on_cnt[i]});
  endtask
  initial begin
    {cyc, stb, we, adr, sel, dw, clr, sns} = '0;
    trip_n = 1'b1;
    rst_n = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rc(`TPW_OFS_PERIOD, 16'h03E8, 16'hFFFF);
    rc(`TPW_OFS_SYNCW, 16'h0027, 16'hFFFF);
    rc(`TPW_OFS_SEG, 16'h003F, 16'hFFFF);
    rc(`TPW_OFS_MODE, 16'h0000, 16'hFFFF);
    rc(`TPW_OFS_STAT, 16'h0001, 16'h0003);
    rc(8'h3C, 16'h0000, 16'hFFFF);
    bus(1'b1, `TPW_OFS_DEAD, 16'hFFFF);
    rc(`TPW_OFS_DEAD, 16'h03FF, 16'hFFFF);
    bus(1'b1, `TPW_OFS_DEAD, 16'h0000);
    bus(1'b1, `TPW_OFS_PERIOD, 16'h0014);
    bus(1'b1, `TPW_OFS_SYNCW, 16'h0003);
    bus(1'b1, `TPW_OFS_DUTY_A, 16'h0006);
    bus(1'b1, `TPW_OFS_DUTY_C, 16'h0014);
    sy();
    sy();
    sy();
    chk("sync spacing", 16'd40, ncyc[15:0]);
    chk("sync width", 16'd4, nhi[15:0]);
    chk("sync event", 16'h0001, {15'h0000, s_irq});
    bus(1'b1, `TPW_OFS_EVT, 16'h0001);
    chk("sync event clear", 16'h0000, {15'h0000, s_irq});
    sy();
    rc(`TPW_OFS_STAT, 16'h0000, 16'h0008);
    repeat (20) @(posedge core_clk);
    rc(`TPW_OFS_STAT, 16'h0008, 16'h0008);
    ck6(48'h0028_2800_1C0C);
    bus(1'b1, `TPW_OFS_DEAD, 16'h0002);
    ck6(48'h0028_2800_1808);
    bus(1'b1, `TPW_OFS_DEAD, 16'h0000);
    bus(1'b1, `TPW_OFS_SEG, 16'h003E);
    ck6(48'h0028_2800_1C00);
    bus(1'b1, `TPW_OFS_SEG, 16'h007F);
    ck6(48'h0028_2800_0C1C);
    bus(1'b1, `TPW_OFS_SEG, 16'h003F);
    bus(1'b1, `TPW_OFS_GATE, 16'h0300);
    ck6(48'h0014_1400_0E06);
    bus(1'b1, `TPW_OFS_GATE, 16'h0000);
    bus(1'b1, `TPW_OFS_MODE, 16'h0040);
    rc(`TPW_OFS_MODE, 16'h0040, 16'hFFFF);
    sy();
    sy();
    sy();
    chk("double sync spacing", 16'd20, ncyc[15:0]);
    bus(1'b1, `TPW_OFS_MODE, 16'h0000);
    sy();
    repeat (8) @(posedge core_clk);
    trip_n <= 1'b0;
    @(negedge core_clk);
    chk("outputs on trip", 16'h0000, {10'h000, g});
    repeat (8) @(posedge core_clk);
    chk("trip event", 16'h0001, {15'h0000, t_irq});
    rc(`TPW_OFS_STAT, 16'h0002, 16'h0003);
    trip_n <= 1'b1;
    cnt6(48'h0);
    bus(1'b1, `TPW_OFS_EVT, 16'h0002);
    chk("trip event clear", 16'h0000, {15'h0000, t_irq});
    bus(1'b1, `TPW_OFS_MODE, 16'h0001);
    ck6(48'h0028_2800_1C0C);
    bus(1'b1, `TPW_OFS_SWTRIP, 16'h0001);
    cnt6(48'h0);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `TPW_OFS_MODE, 16'h0001);
      sy();
      @(posedge core_clk) sns <= 9'h001 << (4 * k);
      @(negedge core_clk);
      chk("outputs on sense fault", 16'h0000, {10'h000, g});
      repeat (4) @(posedge core_clk);
      sns <= 9'h000;
      repeat (8) @(posedge core_clk);
      rc(`TPW_OFS_STAT, 16'h0002, 16'h0002);
    end
    end_sim();
  end
endmodule
